// ---- hw/pio_regs.svh ----
/*
  register offsets, reset values and field limits of the parallel port block.
  assumes an 8-bit register address space with byte-wide registers.
*/
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PIO_ADDR_P1_LATCH 8'h01
`define PIO_ADDR_P2_LATCH 8'h02
`define PIO_ADDR_P3_LATCH 8'h03
`define PIO_ADDR_P3_DRIVE 8'h04
`define PIO_ADDR_P5_LATCH 8'h05
`define PIO_ADDR_P1_PIN 8'h08
`define PIO_ADDR_P2_PIN 8'h09
`define PIO_ADDR_P3_PIN 8'h0a
`define PIO_ADDR_P5_PIN 8'h0b
`define PIO_ADDR_P1_SEG 8'h29
`define PIO_ADDR_P5_SEG 8'h2a

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PIO_RST_P1_LATCH 8'hff
`define PIO_RST_P1_SEG 8'h00
`define PIO_RST_P2_LATCH 3'h7
`define PIO_RST_P3_LATCH 4'hf
`define PIO_RST_P3_DRIVE 4'h0
`define PIO_RST_P5_LATCH 8'hff
`define PIO_RST_P5_SEG 8'h00

// ----------------------------------------------------------------------------
// read filler for bit positions without pins, and unmapped reads
// ----------------------------------------------------------------------------
`define PIO_P2_FILL 5'h00
`define PIO_P3_FILL 4'h0
`define PIO_RD_NONE 8'h00

// ----------------------------------------------------------------------------
// pin sampler layout and idle levels
// ----------------------------------------------------------------------------
`define PIO_NPIN 23
`define PIO_PIN_P1 7:0
`define PIO_PIN_P2 10:8
`define PIO_PIN_P3 14:11
`define PIO_PIN_P5 22:15
`define PIO_RST_P20_LVL 1'b1

`endif

// ---- hw/pio_pkg.sv ----
/*
  types shared by the parallel port block.
  assumes nothing beyond a systemverilog compiler.
*/
package pio_pkg;
  typedef logic [7:0] pio_byte_t;
  // three-stage pin sampler state per bit
  typedef logic [2:0] pio_sync_t;
endpackage

// ---- hw/pio_ports.sv ----
/*
  parallel i/o ports 1, 2, 3 and 5: output latches, pin-level read paths,
  segment select and drive-type control.
  assumes a cpu register port with one-cycle strobes; cpu_rd_i marks the
  first execution state of a read cycle, cpu_wr_i the second execution state
  of a write cycle. pins are split into input, output and output enable
  (enable low means driven).
*/
`timescale 1ns/1ps

`include "pio_regs.svh"

module pio_ports
  import pio_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // cpu register port
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [7:0] cpu_rdata_o,
  // system mode
  input wire logic global_output_enable_i,
  input wire logic stop_mode_i,
  input wire logic dual_clock_mode_i,
  // alternate function sources
  input wire logic [7:0] port1_alt_out_i,
  input wire logic [7:0] port1_seg_i,
  input wire logic [7:0] port5_seg_i,
  input wire logic [3:0] port3_alt_out_i,
  // port 1 pins
  input wire logic [7:0] port1_pin_i,
  output logic [7:0] port1_pin_o,
  output logic [7:0] port1_pin_oe_n_o,
  // port 2 pins
  input wire logic [2:0] port2_pin_i,
  output logic [2:0] port2_pin_o,
  output logic [2:0] port2_pin_oe_n_o,
  // port 3 pins
  input wire logic [3:0] port3_pin_i,
  output logic [3:0] port3_pin_o,
  output logic [3:0] port3_pin_oe_n_o,
  // port 5 pins
  input wire logic [7:0] port5_pin_i,
  output logic [7:0] port5_pin_o,
  output logic [7:0] port5_pin_oe_n_o,
  // to the external interrupt and crystal logic
  output logic port2_bit0_level_o,
  output logic port2_bit0_fall_o,
  output logic low_freq_osc_in_o
);

  // --------------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------------
  pio_byte_t port1_out_latch_r, port1_out_latch_nxt;
  pio_byte_t port1_segment_select_r, port1_segment_select_nxt;
  logic [2:0] port2_out_latch_r, port2_out_latch_nxt;
  logic [3:0] port3_out_latch_r, port3_out_latch_nxt;
  logic [3:0] port3_drive_type_r, port3_drive_type_nxt;
  pio_byte_t port5_out_latch_r, port5_out_latch_nxt;
  pio_byte_t port5_segment_select_r, port5_segment_select_nxt;
  pio_byte_t rdata_r, rdata_nxt;
  logic p20_drv_r, p20_drv_nxt;

  // synchronised pin levels, 23 pins, three stages each
  logic [`PIO_NPIN-1:0] pin_raw;
  logic [`PIO_NPIN-1:0] sync1_r, sync2_r, sync3_r;
  logic [`PIO_NPIN-1:0] sync1_nxt, sync2_nxt, sync3_nxt;
  logic [`PIO_NPIN-1:0] pin_lvl_r, pin_lvl_nxt;

  assign pin_raw = {port5_pin_i, port3_pin_i, port2_pin_i, port1_pin_i};

  // --------------------------------------------------------------------------
  // pin sampler: level accepted once stages two and three agree
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PIO_NPIN; g++) begin : g_sync
      always_comb begin
        sync1_nxt[g] = pin_raw[g];
        sync2_nxt[g] = sync1_r[g];
        sync3_nxt[g] = sync2_r[g];
        // stages two and three must agree before a change is taken
        pin_lvl_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync3_r[g] : pin_lvl_r[g];
      end
      always_ff @(posedge clk_i) begin
        sync1_r[g] <= sync1_nxt[g];
        sync2_r[g] <= sync2_nxt[g];
        sync3_r[g] <= sync3_nxt[g];
        pin_lvl_r[g] <= pin_lvl_nxt[g];
      end
    end
  endgenerate

  // unlatched input paths: plain views of the sampled pins
  logic [7:0] p1_lvl, p5_lvl;
  logic [2:0] p2_lvl;
  logic [3:0] p3_lvl;
  assign p1_lvl = pin_lvl_r[`PIO_PIN_P1];
  assign p2_lvl = pin_lvl_r[`PIO_PIN_P2];
  assign p3_lvl = pin_lvl_r[`PIO_PIN_P3];
  assign p5_lvl = pin_lvl_r[`PIO_PIN_P5];

  // --------------------------------------------------------------------------
  // address decode, shared by the write groups
  // --------------------------------------------------------------------------
  logic hit_p1_latch, hit_p1_seg, hit_p2_latch, hit_p3_latch, hit_p3_drive;
  logic hit_p5_latch, hit_p5_seg;
  always_comb begin
    hit_p1_latch = (cpu_addr_i == `PIO_ADDR_P1_LATCH);
    hit_p1_seg = (cpu_addr_i == `PIO_ADDR_P1_SEG);
    hit_p2_latch = (cpu_addr_i == `PIO_ADDR_P2_LATCH);
    hit_p3_latch = (cpu_addr_i == `PIO_ADDR_P3_LATCH);
    hit_p3_drive = (cpu_addr_i == `PIO_ADDR_P3_DRIVE);
    hit_p5_latch = (cpu_addr_i == `PIO_ADDR_P5_LATCH);
    hit_p5_seg = (cpu_addr_i == `PIO_ADDR_P5_SEG);
  end

  // --------------------------------------------------------------------------
  // port 1 output latch
  // --------------------------------------------------------------------------
  always_comb begin
    port1_out_latch_nxt = port1_out_latch_r;
    if (cpu_wr_i && hit_p1_latch) begin
      port1_out_latch_nxt = cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port1_out_latch_r <= `PIO_RST_P1_LATCH;
    end else begin
      port1_out_latch_r <= port1_out_latch_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // port 1 segment select
  // --------------------------------------------------------------------------
  always_comb begin
    port1_segment_select_nxt = port1_segment_select_r;
    if (cpu_wr_i && hit_p1_seg) begin
      port1_segment_select_nxt = cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port1_segment_select_r <= `PIO_RST_P1_SEG;
    end else begin
      port1_segment_select_r <= port1_segment_select_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // port 2 output latch
  // --------------------------------------------------------------------------
  always_comb begin
    port2_out_latch_nxt = port2_out_latch_r;
    if (cpu_wr_i && hit_p2_latch) begin
      port2_out_latch_nxt = cpu_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port2_out_latch_r <= `PIO_RST_P2_LATCH;
    end else begin
      port2_out_latch_r <= port2_out_latch_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // port 3 output latch and drive type
  // --------------------------------------------------------------------------
  always_comb begin
    port3_out_latch_nxt = port3_out_latch_r;
    port3_drive_type_nxt = port3_drive_type_r;
    if (cpu_wr_i && hit_p3_latch) begin
      port3_out_latch_nxt = cpu_wdata_i[3:0];
    end
    if (cpu_wr_i && hit_p3_drive) begin
      port3_drive_type_nxt = cpu_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port3_out_latch_r <= `PIO_RST_P3_LATCH;
      port3_drive_type_r <= `PIO_RST_P3_DRIVE;
    end else begin
      port3_out_latch_r <= port3_out_latch_nxt;
      port3_drive_type_r <= port3_drive_type_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // port 5 output latch
  // --------------------------------------------------------------------------
  always_comb begin
    port5_out_latch_nxt = port5_out_latch_r;
    if (cpu_wr_i && hit_p5_latch) begin
      port5_out_latch_nxt = cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port5_out_latch_r <= `PIO_RST_P5_LATCH;
    end else begin
      port5_out_latch_r <= port5_out_latch_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // port 5 segment select
  // --------------------------------------------------------------------------
  always_comb begin
    port5_segment_select_nxt = port5_segment_select_r;
    if (cpu_wr_i && hit_p5_seg) begin
      port5_segment_select_nxt = cpu_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port5_segment_select_r <= `PIO_RST_P5_SEG;
    end else begin
      port5_segment_select_r <= port5_segment_select_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // register reads
  // --------------------------------------------------------------------------
  // bit positions without pins read as the filler value
  pio_byte_t p2_latch_rd, p2_pin_rd, p3_latch_rd, p3_drive_rd, p3_pin_rd;
  assign p2_latch_rd = {`PIO_P2_FILL, port2_out_latch_r};
  assign p2_pin_rd = {`PIO_P2_FILL, p2_lvl};
  assign p3_latch_rd = {`PIO_P3_FILL, port3_out_latch_r};
  assign p3_drive_rd = {`PIO_P3_FILL, port3_drive_type_r};
  assign p3_pin_rd = {`PIO_P3_FILL, p3_lvl};

  always_comb begin
    rdata_nxt = `PIO_RD_NONE;
    if (cpu_rd_i) begin
      case (cpu_addr_i)
        `PIO_ADDR_P1_LATCH: rdata_nxt = port1_out_latch_r;
        `PIO_ADDR_P1_SEG: rdata_nxt = port1_segment_select_r;
        `PIO_ADDR_P2_LATCH: rdata_nxt = p2_latch_rd;
        `PIO_ADDR_P3_LATCH: rdata_nxt = p3_latch_rd;
        `PIO_ADDR_P3_DRIVE: rdata_nxt = p3_drive_rd;
        `PIO_ADDR_P5_LATCH: rdata_nxt = port5_out_latch_r;
        `PIO_ADDR_P5_SEG: rdata_nxt = port5_segment_select_r;
        // segment bits read the sampled pad, which is not meaningful
        `PIO_ADDR_P1_PIN: rdata_nxt = p1_lvl;
        `PIO_ADDR_P2_PIN: rdata_nxt = p2_pin_rd;
        `PIO_ADDR_P3_PIN: rdata_nxt = p3_pin_rd;
        `PIO_ADDR_P5_PIN: rdata_nxt = p5_lvl;
        default: rdata_nxt = `PIO_RD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= `PIO_RD_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cpu_rdata_o = rdata_r;

  // --------------------------------------------------------------------------
  // port 1 and port 5 pin drivers
  // --------------------------------------------------------------------------
  // a latch 1 is a weak high that lets an external source pull the pin
  logic [7:0] p1_val, p5_val;
  logic [3:0] p3_val;
  generate
    for (g = 0; g < 8; g++) begin : g_p15
      always_comb begin
        p1_val[g] = port1_segment_select_r[g] ? port1_seg_i[g]
                  : (port1_out_latch_r[g] & port1_alt_out_i[g]);
        port1_pin_o[g] = p1_val[g];
        port1_pin_oe_n_o[g] = ~(global_output_enable_i &
                                (port1_segment_select_r[g] | ~p1_val[g]));
      end
      always_comb begin
        p5_val[g] = port5_segment_select_r[g] ? port5_seg_i[g]
                  : port5_out_latch_r[g];
        port5_pin_o[g] = p5_val[g];
        port5_pin_oe_n_o[g] = ~(global_output_enable_i &
                                (port5_segment_select_r[g] | ~p5_val[g]));
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // port 3 pin drivers
  // --------------------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_p3
      always_comb begin
        p3_val[g] = port3_out_latch_r[g] & port3_alt_out_i[g];
        port3_pin_o[g] = p3_val[g];
        // open drain drives only a low; push-pull drives both levels
        port3_pin_oe_n_o[g] = ~(global_output_enable_i &
                                (port3_drive_type_r[g] | ~p3_val[g]));
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // port 2 pin drivers
  // --------------------------------------------------------------------------
  // the stop pin floats in stop mode whatever the output enable says
  always_comb begin
    port2_pin_o[0] = port2_out_latch_r[0];
    port2_pin_oe_n_o[0] = ~(global_output_enable_i & ~stop_mode_i &
                            ~port2_out_latch_r[0]);
  end

  generate
    for (g = 1; g < 3; g++) begin : g_p2
      always_comb begin
        // crystal pins are released to the oscillator in dual-clock mode
        port2_pin_o[g] = port2_out_latch_r[g];
        port2_pin_oe_n_o[g] = ~(global_output_enable_i & ~dual_clock_mode_i &
                                ~port2_out_latch_r[g]);
      end
    end
  endgenerate

  assign low_freq_osc_in_o = dual_clock_mode_i & p2_lvl[1];

  // --------------------------------------------------------------------------
  // port 2 bit 0 interrupt source: the pad level, so a driven low also fires
  // --------------------------------------------------------------------------
  always_comb begin
    p20_drv_nxt = p2_lvl[0];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      p20_drv_r <= `PIO_RST_P20_LVL;
    end else begin
      p20_drv_r <= p20_drv_nxt;
    end
  end

  assign port2_bit0_level_o = p2_lvl[0];
  assign port2_bit0_fall_o = p20_drv_r & ~p2_lvl[0];

endmodule

// ---- bench/pio_checker.sv ----
/* assertions on the parallel port block.
   assumes binding to pio_ports; sees its ports only. */
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_checker (
  // clock, reset, register port
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_rdata_o,
  // modes and sources
  input wire logic global_output_enable_i,
  input wire logic stop_mode_i,
  input wire logic dual_clock_mode_i,
  input wire logic [7:0] port1_alt_out_i,
  input wire logic [7:0] port1_seg_i,
  // pins
  input wire logic [7:0] port1_pin_o,
  input wire logic [2:0] port2_pin_oe_n_o,
  input wire logic [3:0] port3_pin_o,
  input wire logic [3:0] port3_pin_oe_n_o,
  input wire logic port2_bit0_fall_o
);
  // ----
  // shadows of segment select and drive type
  // ----
  logic [7:0] seg_r, seg_nxt;
  logic [3:0] drv_r, drv_nxt;
  always_comb begin
    seg_nxt = seg_r;
    drv_nxt = drv_r;
    if (cpu_wr_i && cpu_addr_i == `PIO_ADDR_P1_SEG) seg_nxt = cpu_wdata_i;
    if (cpu_wr_i && cpu_addr_i == `PIO_ADDR_P3_DRIVE) drv_nxt = cpu_wdata_i[3:0];
  end
  always_ff @(posedge clk_i) begin
    seg_r <= rst_n_i ? seg_nxt : 8'h00;
    drv_r <= rst_n_i ? drv_nxt : 4'h0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (!cpu_rd_i |=> cpu_rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_p1_write: assert property (cpu_wr_i && cpu_addr_i == 8'h01 && seg_r == 8'h00
    |=> port1_pin_o == ($past(cpu_wdata_i) & port1_alt_out_i))
    else $error("port 1 pin missed write");
  a_p1_hold: assert property (!$past(cpu_wr_i) && $stable(port1_alt_out_i)
    && $stable(port1_seg_i) |-> $stable(port1_pin_o)) else $error("port 1 pin drifted");
  a_p1_seg_route: assert property (((port1_pin_o ^ port1_seg_i) & seg_r) == 8'h00)
    else $error("segment bit not routed");
  a_stop_float: assert property (stop_mode_i |-> port2_pin_oe_n_o[0])
    else $error("stop pin driven in stop");
  a_dual_float: assert property (dual_clock_mode_i |-> &port2_pin_oe_n_o[2:1])
    else $error("crystal pins driven");
  a_fall_pulse: assert property (port2_bit0_fall_o |=> !port2_bit0_fall_o)
    else $error("fall pulse too long");
  a_p3_drive: assert property (global_output_enable_i
    |-> port3_pin_oe_n_o == (port3_pin_o & ~drv_r)) else $error("port 3 drive type wrong");
  c_seg: cover property (cpu_wr_i && cpu_addr_i == `PIO_ADDR_P1_SEG);
  c_fall: cover property (port2_bit0_fall_o);
  c_stop: cover property (stop_mode_i);
endmodule
bind pio_ports pio_checker u_chk (.*);

// ---- bench/pio_pad_model.sv ----
/* external pad model for one port.
   assumes enable-low drive; an undriven pad sits at a pull-up. */
`timescale 1ns/1ps
module pio_pad_model #(parameter int W = 8) (
  // design side
  input wire logic [W-1:0] dut_val_i,
  input wire logic [W-1:0] dut_oe_n_i,
  // far-side source
  input wire logic [W-1:0] ext_val_i,
  input wire logic [W-1:0] ext_en_i,
  // resolved pad level
  output logic [W-1:0] level_o
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level_o[i] = ext_en_i[i] ? ext_val_i[i] : (dut_oe_n_i[i] | dut_val_i[i]);
    end
  end
endmodule

// ---- bench/tb_parallel_io_ports_p1_p2_p3_p5.sv ----
/* self-checking bench for the parallel port block.
   assumes pio_ports, pio_pad_model and the bound checker. */
`timescale 1ns/1ps
module tb_parallel_io_ports_p1_p2_p3_p5;
  logic clk_i = 1'b0, rst_n_i = 1'b0, cpu_wr_i = 1'b0, cpu_rd_i = 1'b0;
  logic global_output_enable_i = 1'b1, stop_mode_i = 1'b0, dual_clock_mode_i = 1'b0;
  logic [7:0] cpu_addr_i = 8'h00, cpu_wdata_i = 8'h00, cpu_rdata_o;
  logic [7:0] port1_alt_out_i = 8'hff, port1_seg_i = 8'h00, port5_seg_i = 8'h00;
  logic [3:0] port3_alt_out_i = 4'hf, port3_pin_i, port3_pin_o, port3_pin_oe_n_o;
  logic [7:0] port1_pin_i, port1_pin_o, port1_pin_oe_n_o;
  logic [7:0] port5_pin_i, port5_pin_o, port5_pin_oe_n_o;
  logic [2:0] port2_pin_i, port2_pin_o, port2_pin_oe_n_o;
  logic port2_bit0_level_o, port2_bit0_fall_o, low_freq_osc_in_o;
  logic [7:0] ext_val = 8'h00, ext_en = 8'h00;
  logic [2:0] ext2_val = 3'h0, ext2_en = 3'h0;
  logic [3:0] ext3_val = 4'h0, ext3_en = 4'h0;
  logic [7:0] ext5_val = 8'h00, ext5_en = 8'h00;
  int n_fail = 0, compares = 0, cyc = 0;
  pio_ports DUT (.*);
  pio_pad_model #(.W(8)) u_pad1 (.dut_val_i(port1_pin_o), .dut_oe_n_i(port1_pin_oe_n_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(port1_pin_i));
  pio_pad_model #(.W(3)) u_pad2 (.dut_val_i(port2_pin_o), .dut_oe_n_i(port2_pin_oe_n_o),
    .ext_val_i(ext2_val), .ext_en_i(ext2_en), .level_o(port2_pin_i));
  pio_pad_model #(.W(4)) u_pad3 (.dut_val_i(port3_pin_o), .dut_oe_n_i(port3_pin_oe_n_o),
    .ext_val_i(ext3_val), .ext_en_i(ext3_en), .level_o(port3_pin_i));
  pio_pad_model #(.W(8)) u_pad5 (.dut_val_i(port5_pin_o), .dut_oe_n_i(port5_pin_oe_n_o),
    .ext_val_i(ext5_val), .ext_en_i(ext5_en), .level_o(port5_pin_i));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ----
  // bus and compare helpers
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge clk_i);
    cpu_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge clk_i);
    cpu_rd_i <= 1'b0;
    #1 chk(cpu_rdata_o, exp);
    @(posedge clk_i);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [7:0] a [8] = '{8'h01, 8'h29, 8'h02, 8'h03, 8'h04, 8'h05, 8'h2a, 8'h00};
    logic [7:0] e [8] = '{8'hff, 8'h00, 8'h07, 8'h0f, 8'h00, 8'hff, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rd(a[i], e[i]);
    end
  endtask
  task automatic t_p1;
    wr(8'h01, 8'h55);
    chk(port1_pin_o, 8'h55);
    chk(port1_pin_oe_n_o, 8'h55);
    rd(8'h01, 8'h55);
    wr(8'h01, 8'hff);
    ext_en <= 8'hff;
    ext_val <= 8'h3c;
    tick(5);
    rd(8'h08, 8'h3c);
    rd(8'h01, 8'hff);
    ext_en <= 8'h00;
    tick(5);
    rd(8'h08, 8'hff);
    port1_seg_i <= 8'ha5;
    wr(8'h29, 8'h0f);
    chk(port1_pin_o & 8'h0f, 8'h05);
    wr(8'h29, 8'h00);
  endtask
  task automatic t_p3;
    wr(8'h03, 8'h0a);
    chk({4'h0, port3_pin_oe_n_o}, 8'h0a);
    wr(8'h04, 8'h0f);
    chk({4'h0, port3_pin_oe_n_o}, 8'h00);
    tick(4);
    rd(8'h0a, 8'h0a);
    wr(8'h03, 8'h0f);
    wr(8'h04, 8'h00);
    port3_alt_out_i <= 4'h6;
    tick(1);
    chk({4'h0, port3_pin_o}, 8'h06);
    port3_alt_out_i <= 4'hf;
    ext3_en <= 4'hf;
    ext3_val <= 4'h5;
    tick(5);
    rd(8'h0a, 8'h05);
    ext3_en <= 4'h0;
    tick(5);
  endtask
  task automatic t_p5;
    port5_seg_i <= 8'h3c;
    wr(8'h2a, 8'hf0);
    wr(8'h05, 8'h00);
    chk(port5_pin_o, 8'h30);
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hff);
    wr(8'h2a, 8'h00);
    ext5_en <= 8'hff;
    ext5_val <= 8'ha5;
    tick(5);
    rd(8'h0b, 8'ha5);
    ext5_en <= 8'h00;
  endtask
  task automatic t_p2;
    ext2_en <= 3'h6;
    ext2_val <= 3'h2;
    tick(5);
    rd(8'h09, 8'h03);
    ext2_en <= 3'h0;
    wr(8'h02, 8'h06);
    for (int i = 0; i < 10 && port2_bit0_fall_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk({7'h0, port2_bit0_fall_o}, 8'h01);
    tick(4);
    rd(8'h09, 8'h06);
    stop_mode_i <= 1'b1;
    tick(1);
    chk({7'h0, port2_pin_oe_n_o[0]}, 8'h01);
    stop_mode_i <= 1'b0;
    wr(8'h02, 8'h00);
    dual_clock_mode_i <= 1'b1;
    tick(5);
    chk({6'h0, port2_pin_oe_n_o[2:1]}, 8'h03);
    chk({7'h0, low_freq_osc_in_o}, 8'h01);
    dual_clock_mode_i <= 1'b0;
    wr(8'h02, 8'h07);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    tick(5);
    rst_n_i <= 1'b1;
    t_reset();
    t_p1();
    t_p3();
    t_p5();
    t_p2();
    report_and_stop();
  end
endmodule
